//--- t1l_neg_resolve.sv
`timescale 1ns/1ps
// Summary of operation
// - high-level mode can run 2.4 V or 1.0 V, chosen by negotiation
// - amplitude mode and advertised level defaults come from latched strap
// - strap low (pull-down default) selects high-level mode
// - role preference bit: 0 prefers follower, 1 prefers leader
// - role bit sets role only with negotiation off; else negotiation owns it
// - advertise own abilities, compare with partner, settle level and role
// - a dropped link restarts negotiation without software
// - writing the restart bit restarts negotiation
// - negotiation is enabled after reset
// - 2.4 V only if both able and at least one requests
// - ability bit 0 means no advertisement and 1.0 V always
// - with negotiation off the role strap gives the default role
// - local prefers follower, partner leader: local follower
// - partner prefers or forces follower: local leader
// - active-low interrupt for any enabled source
// - MAC in reset drives serial data out and timer pin low
// - every reset type brings the logic to a known state
module t1l_neg_resolve
    import t1l_neg_pkg::*;
#(
    parameter int RESET_CYCLES = SUB_RESET_CYC
) (
    // clock and reset
    input  wire logic             SYS_CLK,
    input  wire logic             RST_N,
    // register port
    input  wire logic [7:0]       REG_ADDR,
    input  wire logic [31:0]      REG_WDATA,
    input  wire logic             REG_WR,
    input  wire logic             REG_RD,
    output logic      [31:0]      REG_RDATA,
    // straps, sampled after reset release and again on each soft reset
    input  wire logic             HIGH_LEVEL_TX_STRAP,
    input  wire logic             ROLE_SELECT_STRAP,
    // link partner page exchange
    input  wire logic             PAGE_VALID,
    input  wire page_t            PAGE_RX,
    output page_t                 PAGE_TX,
    output logic                  NEG_BUSY,
    input  wire logic             LINK_UP,
    // outcome to the transmitter
    output logic                  TX_HIGH_LEVEL,
    output logic                  ROLE_LEADER,
    // event sources from mac and phy
    input  wire logic [IRQ_W-1:0] EVENT_IN,
    output logic                  INT_N,
    // mac-reset pin effects
    input  wire logic             SPI_SDO_IN,
    input  wire logic             TIMESTAMP_TIMER_OUT_IN,
    output logic                  SPI_SDO,
    output logic                  TIMESTAMP_TIMER_OUT,
    output logic                  MAC_RESET,
    output logic                  PHY_RESET
);

    initial begin
        if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << RCNT_W))
            $error("RESET_CYCLES out of range");
    end

    logic             strap_done;
    logic             hi_mode;
    logic             neg_en;
    logic             role_pref;
    logic             hi_abl;
    logic             hi_req;
    logic             restart_req;
    neg_state_t       state;
    result_t          res;
    logic             link_q;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic [RCNT_W-1:0] mac_cnt;
    logic [RCNT_W-1:0] phy_cnt;
    logic             soft_rst;

    // decode
    wire sel_ctrl  = REG_ADDR == ADDR_NEG_CTRL;
    wire sel_adv   = REG_ADDR == ADDR_NEG_ADV;
    wire sel_res   = REG_ADDR == ADDR_NEG_RESULT;
    wire sel_st0   = REG_ADDR == ADDR_IRQ_STAT0;
    wire sel_st1   = REG_ADDR == ADDR_IRQ_STAT1;
    wire sel_mask  = REG_ADDR == ADDR_IRQ_MASK;
    wire sel_rst   = REG_ADDR == ADDR_RESET_CTRL;
    wire wr_ctrl   = REG_WR && sel_ctrl;
    wire wr_adv    = REG_WR && sel_adv;
    wire wr_rst    = REG_WR && sel_rst;
    wire wr_restart = wr_ctrl && REG_WDATA[CTRL_RESTART_BIT];
    wire link_drop = link_q && !LINK_UP;
    wire phy_held  = phy_cnt != '0;
    wire mac_held  = mac_cnt != '0;
    wire local_rst = soft_rst || phy_held;

    // partner and local ability combine
    wire adv_abl   = hi_mode && hi_abl;
    wire both_abl  = adv_abl && PAGE_RX.hi_abl;
    wire any_req   = hi_req || PAGE_RX.hi_req;
    wire next_hi   = both_abl && any_req;
    // partner follower -> we lead; we prefer follower and it leads -> follow
    wire next_lead = !PAGE_RX.leader ? 1'b1 :
                     (role_pref && !PAGE_RX.forced);

    // strap latch: clocked capture after release, low strap = high mode
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_done <= 1'b0;
            hi_mode    <= 1'b1;
        end else if (!strap_done || soft_rst) begin
            strap_done <= 1'b1;
            hi_mode    <= !HIGH_LEVEL_TX_STRAP;
        end
    end

    // control bits
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            neg_en    <= 1'b1;
            role_pref <= 1'b0;
            hi_abl    <= 1'b1;
            hi_req    <= 1'b1;
        end else if (!strap_done || soft_rst) begin
            neg_en    <= 1'b1;
            role_pref <= ROLE_SELECT_STRAP;
            hi_abl    <= !HIGH_LEVEL_TX_STRAP;
            hi_req    <= !HIGH_LEVEL_TX_STRAP;
        end else begin
            if (wr_ctrl) begin
                neg_en <= REG_WDATA[CTRL_NEG_EN_BIT];
                if (!REG_WDATA[CTRL_NEG_EN_BIT] || !neg_en)
                    role_pref <= REG_WDATA[CTRL_ROLE_PREF];
            end
            if (wr_adv) begin
                hi_abl <= REG_WDATA[ADV_HI_ABL_BIT];
                hi_req <= REG_WDATA[ADV_HI_REQ_BIT];
            end
            if (state == NEG_PAGE && PAGE_VALID && neg_en)
                role_pref <= next_lead;
        end
    end

    // negotiation sequence
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state       <= NEG_IDLE;
            res         <= '0;
            link_q      <= 1'b0;
            restart_req <= 1'b0;
        end else if (local_rst) begin
            state       <= NEG_IDLE;
            res         <= '0;
            link_q      <= 1'b0;
            restart_req <= 1'b0;
        end else begin
            link_q      <= LINK_UP;
            restart_req <= wr_restart || link_drop;
            case (state)
                NEG_IDLE: begin
                    if (neg_en && strap_done)
                        state <= NEG_PAGE;
                    else if (!neg_en) begin
                        res.done     <= 1'b0;
                        res.hi_level <= 1'b0;
                        res.leader   <= role_pref;
                    end
                end
                NEG_PAGE: begin
                    if (!neg_en)
                        state <= NEG_IDLE;
                    else if (PAGE_VALID) begin
                        res.done     <= 1'b1;
                        res.hi_level <= next_hi;
                        res.leader   <= next_lead;
                        state        <= NEG_DONE;
                    end
                end
                NEG_DONE: begin
                    if (restart_req || !neg_en) begin
                        res.done <= 1'b0;
                        state    <= NEG_IDLE;
                    end
                end
                default: state <= NEG_IDLE;
            endcase
        end
    end

    assign PAGE_TX.hi_abl = adv_abl;
    assign PAGE_TX.hi_req = adv_abl && hi_req;
    assign PAGE_TX.leader = role_pref;
    assign PAGE_TX.forced = 1'b0;
    assign NEG_BUSY       = state == NEG_PAGE;
    assign TX_HIGH_LEVEL  = res.hi_level;
    assign ROLE_LEADER    = res.leader;

    // sticky status, set wins over read clear
    wire rd_clear = REG_RD && (sel_st0 || sel_st1);
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            stat <= '0;
            mask <= IRQ_MASK_RST;
        end else begin
            stat <= (rd_clear ? '0 : stat) | EVENT_IN;
            if (REG_WR && sel_mask)
                mask <= REG_WDATA[IRQ_W-1:0];
        end
    end
    assign INT_N = !(|(stat & mask));

    // local reset timers
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mac_cnt  <= '0;
            phy_cnt  <= '0;
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_rst && REG_WDATA[RST_SOFT_BIT];
            if ((wr_rst && REG_WDATA[RST_MAC_BIT]) || soft_rst)
                mac_cnt <= RCNT_W'(RESET_CYCLES);
            else if (mac_held)
                mac_cnt <= mac_cnt - 1'b1;
            if ((wr_rst && REG_WDATA[RST_PHY_BIT]) || soft_rst)
                phy_cnt <= RCNT_W'(RESET_CYCLES);
            else if (phy_held)
                phy_cnt <= phy_cnt - 1'b1;
        end
    end

    wire mac_in_rst = !RST_N || mac_held;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            SPI_SDO             <= 1'b0;
            TIMESTAMP_TIMER_OUT <= 1'b0;
        end else begin
            SPI_SDO             <= mac_in_rst ? 1'b0 : SPI_SDO_IN;
            TIMESTAMP_TIMER_OUT <= mac_in_rst ? 1'b0 : TIMESTAMP_TIMER_OUT_IN;
        end
    end
    assign MAC_RESET = mac_held;
    assign PHY_RESET = phy_held;

    // read mux; the two status words split the sources for the host
    wire [31:0] rd_ctrl = {29'h0, role_pref, 1'b0, neg_en};
    wire [31:0] rd_adv  = {30'h0, hi_req, adv_abl};
    wire [31:0] rd_res  = {28'h0, hi_mode, res.leader,
                           res.hi_level, res.done};
    wire [31:0] rd_st0  = {29'h0, stat[2:0]};
    wire [31:0] rd_st1  = {29'h0, stat[5:3]};
    wire [31:0] rd_msk  = {26'h0, mask};
    wire [31:0] rd_rst  = {30'h0, phy_held, mac_held};
    wire [31:0] rd_mux  = sel_ctrl ? rd_ctrl :
                          sel_adv  ? rd_adv  :
                          sel_res  ? rd_res  :
                          sel_st0  ? rd_st0  :
                          sel_st1  ? rd_st1  :
                          sel_mask ? rd_msk  :
                          sel_rst  ? rd_rst  : 32'h0;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N)
            REG_RDATA <= '0;
        else
            REG_RDATA <= REG_RD ? rd_mux : 32'h0;
    end

    // assertions
    a_neg_en_reset: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(strap_done) |-> neg_en)
        else $error("negotiation not enabled after reset");
    a_level_resolve: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == NEG_PAGE && neg_en && PAGE_VALID && !local_rst) |=>
        TX_HIGH_LEVEL == $past(next_hi))
        else $error("wrong level resolved");
    a_abl_low_1v: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == NEG_PAGE && neg_en && PAGE_VALID && !local_rst &&
         !PAGE_TX.hi_abl) |=> !TX_HIGH_LEVEL)
        else $error("high level without ability");
    a_follow_leader: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == NEG_PAGE && neg_en && PAGE_VALID && !local_rst &&
         !role_pref && PAGE_RX.leader) |=> !ROLE_LEADER)
        else $error("should be follower");
    a_lead_follower: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == NEG_PAGE && neg_en && PAGE_VALID && !local_rst &&
         !PAGE_RX.leader) |=> ROLE_LEADER)
        else $error("should be leader");
    a_link_restart: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == NEG_DONE && link_drop && !local_rst && neg_en) |=>
        ##1 state == NEG_IDLE)
        else $error("no restart on link drop");
    a_sw_restart: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == NEG_DONE && wr_restart && !local_rst && neg_en) |=>
        ##1 state == NEG_IDLE)
        else $error("no restart on write");
    a_int_level: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (EVENT_IN & mask) != '0 |=> !INT_N)
        else $error("interrupt not raised");
    a_mac_pins_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        mac_held |=> (!SPI_SDO && !TIMESTAMP_TIMER_OUT))
        else $error("pins not low in mac reset");
    a_role_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == NEG_IDLE && !neg_en && !local_rst) |=>
        ROLE_LEADER == $past(role_pref))
        else $error("role not from bit");

    c_neg_done: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        state == NEG_PAGE ##1 state == NEG_DONE);
    c_high_lvl: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(TX_HIGH_LEVEL));
    c_drop_rst: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        state == NEG_DONE && link_drop);
    c_mac_rst: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        $fell(mac_held));

endmodule : t1l_neg_resolve

//--- t1l_neg_pkg.sv
package t1l_neg_pkg;

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_NEG_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_NEG_ADV    = 8'h04;
    localparam logic [7:0] ADDR_NEG_RESULT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT0  = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT1  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;
    localparam logic [7:0] ADDR_RESET_CTRL = 8'h18;

    // negotiation control fields
    localparam int CTRL_NEG_EN_BIT   = 0;
    localparam int CTRL_RESTART_BIT  = 1;
    localparam int CTRL_ROLE_PREF    = 2;
    // advertisement fields
    localparam int ADV_HI_ABL_BIT    = 0;
    localparam int ADV_HI_REQ_BIT    = 1;
    // reset control fields (self clearing)
    localparam int RST_MAC_BIT       = 0;
    localparam int RST_PHY_BIT       = 1;
    localparam int RST_SOFT_BIT      = 2;

    // interrupt sources, one bit each
    localparam int IRQ_W             = 6;
    localparam int IRQ_LINK          = 0;
    localparam int IRQ_RX_AVAIL      = 1;
    localparam int IRQ_TX_DONE       = 2;
    localparam int IRQ_TS_CAPT       = 3;
    localparam int IRQ_OP_ERR        = 4;
    localparam int IRQ_PHY_EVT       = 5;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;

    // local resets last about 1.2 us
    localparam real SUB_RESET_NS     = 1200.0;
    localparam real CLK_PERIOD_NS    = 5.0;
    localparam int  SUB_RESET_CYC    = int'(SUB_RESET_NS / CLK_PERIOD_NS);
    localparam int  RCNT_W           = 9;

    typedef enum logic [1:0] {
        NEG_IDLE  = 2'b00,
        NEG_PAGE  = 2'b01,
        NEG_DONE  = 2'b10
    } neg_state_t;

    // partner page as received
    typedef struct packed {
        logic hi_abl;
        logic hi_req;
        logic leader;
        logic forced;
    } page_t;

    // negotiated outcome
    typedef struct packed {
        logic done;
        logic hi_level;
        logic leader;
    } result_t;

endpackage : t1l_neg_pkg

//--- t1l_far_phy.sv
`timescale 1ns/1ps
module t1l_far_phy
    import t1l_neg_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // bench control
    input  wire page_t      page_cfg,
    input  wire logic [3:0] delay,
    input  wire logic       drop,
    // page exchange
    input  wire logic       busy,
    output logic            page_valid,
    output page_t           page_rx,
    output logic            link_up
);
    logic [3:0] wait_cnt;
    page_t      last;

    // released lines show the inverse so a stale page never looks fresh
    assign page_rx = page_valid ? last : ~last;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt   <= 4'h0;
            page_valid <= 1'b0;
            last       <= '0;
            link_up    <= 1'b0;
        end else if (page_valid) begin
            page_valid <= 1'b0;
            link_up    <= 1'b1;
        end else if (busy && wait_cnt >= delay) begin
            page_valid <= 1'b1;
            last       <= page_cfg;
            wait_cnt   <= 4'h0;
        end else begin
            wait_cnt <= busy ? wait_cnt + 4'h1 : 4'h0;
            link_up  <= link_up & ~drop;
        end
    end
endmodule : t1l_far_phy

//--- test_t1l_neg_resolve.sv
`timescale 1ns/1ps
module test_t1l_neg_resolve;
    import t1l_neg_pkg::*;

    localparam int RC = 4;

    logic             sys_clk, rst_n, reg_wr, reg_rd, hi_strap, role_strap;
    logic [7:0]       reg_addr;
    logic [31:0]      reg_wdata, reg_rdata, rdata;
    logic             page_valid, neg_busy, link_up, link_drop;
    page_t            page_rx, page_cfg, page_tx;
    logic [3:0]       delay;
    logic             tx_high, role_leader, int_n, sdo_in, ts_in, sdo, ts_out;
    logic             mac_reset, phy_reset;
    logic [IRQ_W-1:0] event_in;
    int               mismatches, comparisons;

    t1l_neg_resolve #(.RESET_CYCLES(RC)) dut (
        .SYS_CLK(sys_clk), .RST_N(rst_n),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .HIGH_LEVEL_TX_STRAP(hi_strap), .ROLE_SELECT_STRAP(role_strap),
        .PAGE_VALID(page_valid), .PAGE_RX(page_rx), .PAGE_TX(page_tx),
        .NEG_BUSY(neg_busy), .LINK_UP(link_up),
        .TX_HIGH_LEVEL(tx_high), .ROLE_LEADER(role_leader),
        .EVENT_IN(event_in), .INT_N(int_n),
        .SPI_SDO_IN(sdo_in), .TIMESTAMP_TIMER_OUT_IN(ts_in), .SPI_SDO(sdo),
        .TIMESTAMP_TIMER_OUT(ts_out), .MAC_RESET(mac_reset),
        .PHY_RESET(phy_reset)
    );

    t1l_far_phy partner (
        .clk(sys_clk), .rst_n(rst_n), .page_cfg(page_cfg), .delay(delay),
        .drop(link_drop), .busy(neg_busy), .page_valid(page_valid),
        .page_rx(page_rx), .link_up(link_up)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // waits for a page exchange to start and then to finish
    task automatic settle();
        int n;
        n = 0;
        #1;
        while (neg_busy !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(neg_busy, 1'b1);
        while (neg_busy !== 1'b0 && n < 60) begin
            tick(1);
            n++;
        end
        chk(neg_busy, 1'b0);
    endtask : settle

    task automatic pulse(input logic [IRQ_W-1:0] v);
        @(posedge sys_clk);
        event_in <= v;
        @(posedge sys_clk);
        event_in <= '0;
        #1;
    endtask : pulse

    task automatic test_reset_values();
        rd(ADDR_NEG_CTRL, rdata);
        chk(rdata, 32'h5);
        chk(tx_high, 1'b1);
        rd(ADDR_NEG_ADV, rdata);
        chk(rdata, 32'h3);
        rd(ADDR_IRQ_MASK, rdata);
        chk(rdata, 32'h0);
        rd(8'h40, rdata);
        chk(rdata, 32'h0);
        chk(int_n, 1'b1);
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_resolution();
        logic [1:0] adv;
        logic       hi, lead;
        for (int a = 1; a < 4; a++) begin
            for (int pref = 0; pref < 2; pref++) begin
                for (int p = 0; p < 16; p++) begin
                    adv = 2'(a);
                    page_cfg = page_t'(4'(p));
                    delay = p[0] ? 4'h9 : 4'h0;
                    wr(ADDR_NEG_ADV, {30'h0, adv});
                    wr(ADDR_NEG_CTRL, {29'h0, pref[0], 2'b00});
                    tick(2);
                    chk(role_leader, pref[0]);
                    chk(tx_high, 1'b0);
                    wr(ADDR_NEG_CTRL, {29'h0, pref[0], 2'b11});
                    settle();
                    hi = adv[0] & page_cfg.hi_abl
                       & (adv[1] | page_cfg.hi_req);
                    lead = ~page_cfg.leader | (pref[0] & ~page_cfg.forced);
                    chk(tx_high, hi);
                    chk(role_leader, lead);
                    chk(page_tx, {adv[0], adv[0] & adv[1], lead, 1'b0});
                    rd(ADDR_NEG_RESULT, rdata);
                    chk(rdata, {28'h0, 1'b1, lead, hi, 1'b1});
                end
            end
        end
        $display("test resolution done");
    endtask : test_resolution

    task automatic test_link_drop();
        chk(link_up, 1'b1);
        @(posedge sys_clk);
        link_drop <= 1'b1;
        @(posedge sys_clk);
        link_drop <= 1'b0;
        settle();
        chk(link_up, 1'b1);
        $display("test link_drop done");
    endtask : test_link_drop

    task automatic test_interrupts();
        logic [7:0] w;
        for (int e = 0; e < IRQ_W; e++) begin
            w = (e < 3) ? ADDR_IRQ_STAT0 : ADDR_IRQ_STAT1;
            wr(ADDR_IRQ_MASK, 32'h1 << e);
            pulse(~(6'h1 << e));
            chk(int_n, 1'b1);
            rd(w, rdata);
            chk(rdata, 32'h7 & ~(32'h1 << (e % 3)));
            pulse(6'h1 << e);
            chk(int_n, 1'b0);
            rd(w, rdata);
            chk(rdata, 32'h1 << (e % 3));
            chk(int_n, 1'b1);
        end
        $display("test interrupts done");
    endtask : test_interrupts

    task automatic test_resets();
        for (int b = 0; b < 3; b++) begin
            hi_strap <= (b == 2);
            wr(ADDR_RESET_CTRL, 32'h1 << b);
            tick(2);
            chk(mac_reset, b != 1);
            chk(phy_reset, b != 0);
            chk(sdo, b == 1);
            chk(ts_out, b == 1);
            tick(RC + 4);
            chk({mac_reset, phy_reset, sdo, ts_out}, 4'h3);
        end
        rd(ADDR_NEG_ADV, rdata);
        chk(rdata, 32'h0);
        hi_strap <= 1'b0;
        wr(ADDR_RESET_CTRL, 32'h4);
        tick(RC + 4);
        rd(ADDR_NEG_ADV, rdata);
        chk(rdata, 32'h3);
        $display("test resets done");
    endtask : test_resets

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        {rst_n, reg_wr, reg_rd, link_drop, hi_strap} = '0;
        {reg_addr, reg_wdata, event_in} = '0;
        role_strap = 1'b1;
        {sdo_in, ts_in} = 2'b11;
        page_cfg = page_t'(4'hc);
        delay = 4'h0;
        tick(10);
        rst_n = 1'b1;
        tick(30);
        test_reset_values();
        test_resolution();
        test_link_drop();
        test_interrupts();
        test_resets();
        print_verdict();
    end

    // about 2000 cycles are expected; cut off well beyond that
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end
endmodule : test_t1l_neg_resolve
